// file: sib_pkg.sv
// Constants, codes and state types of the SPI to I2C command bridge.
// Assumes a 50 MHz system clock and a mode 3 SPI host on the link side.
//
// Notes on behaviour
// RULE1: Success, and reset, report 0xF0 status.
// RULE2: Address not acknowledged gives 0xF1 and interrupt.
// RULE3: Data byte not acknowledged gives 0xF2.
// RULE4: Busy shows 0xF3, no interrupt, host waits.
// RULE5: Transaction exceeding time-out gives 0xF8 and interrupt.
// RULE6: Invalid byte count gives 0xF9 and interrupt.
// RULE7: Byte-oriented I2C master, at most 400 kHz.
// RULE8: SPI slave only, host clock, 3 Mbit/s.
// RULE9: Low chip select selects; may stay low.
// RULE10: Write: 0x00, count, address, data bytes.
// RULE11: Write command sends buffered bytes in order.
// RULE12: Finished write raises interrupt and readable status.
// RULE13: Write ignores address bit 0, always writes.
// RULE14: Read stores received bytes, then interrupts.
// RULE15: Read ignores address bit 0, at most 96.
// RULE16: Read data returned only by read-buffer.
// RULE17: Read after write: write, read, store, interrupt.
// RULE18: Read-buffer command shifts receive buffer out.
// RULE19: New read replaces unfetched receive buffer.
// RULE20: Write after write: N bytes, then M bytes.
// RULE21: Config 0x42 LSB first, 0x81 MSB first.
// RULE22: 16-bit time-out counter, nine low ones loaded.
// RULE23: Lost arbitration retries START when bus free.
// RULE24: Register write: 0x20, address, one data byte.
// RULE25: Register read: 0x21, address, dummy; value returned.
// RULE26: SPI clock idles high, sampled on rising edge.
// RULE27: Count zero or above 96 starts nothing.
package sib_pkg;

	localparam int          CLK_HZ       = 50_000_000;
	localparam int          I2C_MAX_HZ   = 400_000;
	localparam int          QUARTER_CYC  =
		(CLK_HZ + 4 * I2C_MAX_HZ - 1) / (4 * I2C_MAX_HZ);
	localparam logic [7:0]  QUARTER_LOAD = 8'(QUARTER_CYC - 1);
	localparam logic [6:0]  TO_DIV_LAST  = 7'h7F;
	localparam logic [8:0]  TO_ONES      = 9'h1FF;
	localparam logic [2:0]  BUS_FREE_QTR = 3'h4;
	localparam logic [7:0]  MAX_COUNT    = 8'h60;

	localparam logic [7:0]  ST_OK        = 8'hF0;
	localparam logic [7:0]  ST_NAK_ADDR  = 8'hF1;
	localparam logic [7:0]  ST_NAK_DATA  = 8'hF2;
	localparam logic [7:0]  ST_BUSY      = 8'hF3;
	localparam logic [7:0]  ST_TIMEOUT   = 8'hF8;
	localparam logic [7:0]  ST_BAD_COUNT = 8'hF9;

	localparam logic [7:0]  CMD_WRITE    = 8'h00;
	localparam logic [7:0]  CMD_READ     = 8'h01;
	localparam logic [7:0]  CMD_RAW      = 8'h02;
	localparam logic [7:0]  CMD_WAW      = 8'h03;
	localparam logic [7:0]  CMD_RBUF     = 8'h06;
	localparam logic [7:0]  CMD_CONFIG   = 8'h18;
	localparam logic [7:0]  CMD_REG_WR   = 8'h20;
	localparam logic [7:0]  CMD_REG_RD   = 8'h21;

	localparam logic [7:0]  CFG_LSB      = 8'h42;
	localparam logic [7:0]  CFG_MSB      = 8'h81;
	localparam logic [7:0]  REG_TIMEOUT  = 8'h04;
	localparam logic [7:0]  REG_STATUS   = 8'h05;
	localparam logic [7:0]  TIMEOUT_RST  = 8'h00;

	typedef enum logic [2:0] {
		I_IDLE  = 3'b000,
		I_START = 3'b001,
		I_BIT   = 3'b010,
		I_STOP  = 3'b011,
		I_WAIT  = 3'b100
	} sib_i2c_e;

	typedef enum logic [3:0] {
		P_CMD   = 4'b0000,
		P_N1    = 4'b0001,
		P_N2    = 4'b0010,
		P_A1    = 4'b0011,
		P_D1    = 4'b0100,
		P_A2    = 4'b0101,
		P_D2    = 4'b0110,
		P_CFG   = 4'b0111,
		P_RADDR = 4'b1000,
		P_RDATA = 4'b1001,
		P_RBUF  = 4'b1010,
		P_IGN   = 4'b1011
	} sib_parse_e;

endpackage

// file: sib_bridge.sv
// SPI slave command interpreter driving an I2C-bus master.
// Assumes spiClock comes from the host; SCL and SDA are open drain with
// pull-ups outside, pulled low while their enable is high.
`timescale 1ns/1ps
`default_nettype none
module sib_bridge (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic spiClock,
	input  wire logic spiSelectN,
	input  wire logic spiMosi,
	output var  logic spiMiso,
	output var  logic spiMisoOe,
	input  wire logic sclIn,
	output var  logic sclOut,
	output var  logic sclOe,
	input  wire logic sdaIn,
	output var  logic sdaOut,
	output var  logic sdaOe,
	output var  logic intN
);
	import sib_pkg::*;

	typedef struct packed {
		logic [2:0] bitCnt;
		logic [6:0] rxSh;
		logic [7:0] rxByte;
		logic       rxTog;
	} sib_spi_s;

	typedef struct packed {
		logic [7:0] txSh;
	} sib_neg_s;

	typedef struct packed {
		logic                 csS1, csS2, togS1, togS2, togS3;
		logic                 sclS1, sclS2, sdaS1, sdaS2;
		logic [7:0]           status;
		logic                 intN, misoOe, lsbFirst, sclOut, sdaOut;
		logic [7:0]           toReg, cmd, regAddr, n1, n2, addr1, addr2;
		logic [7:0]           cnt, rxLen, txData, byteLeft, pend, ioByte;
		logic [6:0]           txWr, rdIdx, txIdx, rxIdx, toDiv;
		logic [95:0][7:0]     txBuf;
		logic [95:0][7:0]     rxBuf;
		sib_parse_e           ph;
		sib_i2c_e             st;
		logic [7:0]           div;
		logic [1:0]           q;
		logic [3:0]           bitN;
		logic                 isAddr, rdData, ack, seg, sclOe, sdaOe;
		logic [15:0]          toCnt;
		logic [2:0]           freeCnt;
	} sib_sys_s;

	sib_spi_s s, next_spi;
	sib_neg_s ng, next_neg;
	sib_sys_s r, next_sys;

	logic       spiRstN;
	logic       byteEvt;
	logic [7:0] rxB;
	logic       tick;
	logic       stretch;
	logic       adv;
	logic       twoSeg;
	logic       segRead;
	logic [7:0] segLen;
	logic [7:0] segAddr;
	logic       outBit;
	logic       badCnt;
	logic       toHit;

	function automatic logic badN(input logic [7:0] v);
		return (v == 8'h00) || (v > MAX_COUNT);
	endfunction

	function automatic logic [7:0] ord(input logic [7:0] v, input logic l);
		logic [7:0] rev;
		rev = {<<{v}};
		return l ? rev : v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// SPI link side, clocked by the host
	// RULE9 select resets link
	assign spiRstN = rst_n & ~spiSelectN;

	// RULE26 rising edge sampling
	always_comb begin
		next_spi = s;
		next_spi.bitCnt = s.bitCnt + 3'h1;
		next_spi.rxSh = {s.rxSh[5:0], spiMosi};
		if (s.bitCnt == 3'h7) begin
			next_spi.rxByte = {s.rxSh, spiMosi};
			next_spi.rxTog = ~s.rxTog;
		end
	end

	// RULE8 host clocks slave
	always_ff @(posedge spiClock or negedge spiRstN) begin
		if (!spiRstN)
			s <= '0;
		else
			s <= next_spi;
	end

	// RULE26 falling edge shifting
	always_comb begin
		next_neg = ng;
		if (s.bitCnt == 3'h0)
			next_neg.txSh = r.txData;
		else
			next_neg.txSh = {ng.txSh[6:0], 1'b0};
	end

	always_ff @(negedge spiClock or negedge spiRstN) begin
		if (!spiRstN)
			ng <= '0;
		else
			ng <= next_neg;
	end

	////////////////////////////////////////////////////////////////////////
	// System side helpers
	assign byteEvt = (r.togS2 != r.togS3) && !r.csS2;
	// RULE21 bit order applied
	assign rxB = ord(s.rxByte, r.lsbFirst);
	assign tick = (r.div == 8'h00);
	assign stretch = (r.st != I_WAIT) && (r.q == 2'h2) && !r.sclS2;
	assign adv = tick && !stretch && (r.st != I_IDLE);
	assign twoSeg = (r.cmd == CMD_RAW) || (r.cmd == CMD_WAW);
	assign segRead = r.seg ? (r.cmd == CMD_RAW) : (r.cmd == CMD_READ);
	assign segLen = r.seg ? r.n2 : r.n1;
	assign segAddr = (r.seg && r.cmd == CMD_WAW) ? r.addr2 : r.addr1;
	assign outBit = (r.bitN == 4'h8) ? (!r.rdData || r.byteLeft == 8'h00)
		: (r.rdData || r.ioByte[7]);
	// RULE27 zero or oversize count
	assign badCnt = badN(r.n1) || (twoSeg && badN(r.n2)) ||
		(r.cmd == CMD_WAW && ({1'b0, r.n1} + {1'b0, r.n2}) > {1'b0, MAX_COUNT});
	// RULE5 time-out reached
	assign toHit = (r.st != I_IDLE) && r.toReg[0] && (r.toCnt == 16'h0000);

	////////////////////////////////////////////////////////////////////////
	// Command parser and I2C engine
	always_comb begin
		logic go;
		logic lost;
		logic nRd;
		logic [7:0] left;
		go = 1'b0;
		lost = 1'b0;
		nRd = 1'b0;
		left = 8'h00;
		next_sys = r;
		next_sys.csS1 = spiSelectN;
		next_sys.csS2 = r.csS1;
		next_sys.togS1 = s.rxTog;
		next_sys.togS2 = r.togS1;
		next_sys.togS3 = r.togS2;
		next_sys.sclS1 = sclIn;
		next_sys.sclS2 = r.sclS1;
		next_sys.sdaS1 = sdaIn;
		next_sys.sdaS2 = r.sdaS1;
		next_sys.misoOe = !r.csS2;

		if (r.csS2) begin
			next_sys.ph = P_CMD;
		end else if (byteEvt) begin
			next_sys.txData = 8'h00;
			case (r.ph)
			P_CMD: begin
				next_sys.cmd = rxB;
				next_sys.txWr = 7'h00;
				next_sys.cnt = 8'h00;
				case (rxB)
				CMD_WRITE, CMD_READ, CMD_RAW, CMD_WAW: next_sys.ph = P_N1;
				CMD_CONFIG: next_sys.ph = P_CFG;
				CMD_REG_WR, CMD_REG_RD: next_sys.ph = P_RADDR;
				// RULE18 buffer shifted out
				CMD_RBUF: begin
					next_sys.txData = ord(r.rxBuf[0], r.lsbFirst);
					next_sys.rdIdx = 7'h01;
					next_sys.ph = (r.rxLen == 8'h00) ? P_CMD : P_RBUF;
				end
				default: next_sys.ph = P_CMD;
				endcase
			end
			P_N1: begin
				next_sys.n1 = rxB;
				next_sys.ph = twoSeg ? P_N2 : P_A1;
			end
			P_N2: begin
				next_sys.n2 = rxB;
				next_sys.ph = P_A1;
			end
			P_A1: begin
				next_sys.addr1 = rxB;
				if (badCnt) begin
					// RULE6 invalid count flagged
					next_sys.status = ST_BAD_COUNT;
					next_sys.intN = 1'b0;
					next_sys.ph = P_IGN;
				end else if (r.cmd == CMD_READ) begin
					go = 1'b1;
				end else begin
					next_sys.ph = P_D1;
				end
			end
			// RULE11 data buffered in order
			P_D1, P_D2: begin
				next_sys.txBuf[r.txWr] = rxB;
				next_sys.txWr = r.txWr + 7'h01;
				next_sys.cnt = r.cnt + 8'h01;
				if (r.cnt + 8'h01 == ((r.ph == P_D1) ? r.n1 : r.n2)) begin
					// RULE20 second slave follows
					if (r.ph == P_D1 && r.cmd == CMD_WAW) begin
						next_sys.cnt = 8'h00;
						next_sys.ph = P_A2;
					end else begin
						go = 1'b1;
					end
				end
			end
			P_A2: begin
				next_sys.addr2 = rxB;
				next_sys.ph = P_D2;
			end
			// RULE21 bit order select
			P_CFG: begin
				if (rxB == CFG_LSB)
					next_sys.lsbFirst = 1'b1;
				else if (rxB == CFG_MSB)
					next_sys.lsbFirst = 1'b0;
				next_sys.ph = P_CMD;
			end
			// RULE25 register read returned
			P_RADDR: begin
				next_sys.regAddr = rxB;
				next_sys.ph = P_RDATA;
				if (r.cmd == CMD_REG_RD) begin
					if (rxB == REG_STATUS) begin
						next_sys.txData = ord(r.status, r.lsbFirst);
						next_sys.intN = 1'b1;
					end else if (rxB == REG_TIMEOUT) begin
						next_sys.txData = ord(r.toReg, r.lsbFirst);
					end
				end
			end
			// RULE24 single register write
			P_RDATA: begin
				if (r.cmd == CMD_REG_WR && r.regAddr == REG_TIMEOUT)
					next_sys.toReg = rxB;
				next_sys.ph = P_CMD;
			end
			// RULE16 data only here
			P_RBUF: begin
				if ({1'b0, r.rdIdx} == r.rxLen) begin
					next_sys.ph = P_CMD;
				end else begin
					next_sys.txData = ord(r.rxBuf[r.rdIdx], r.lsbFirst);
					next_sys.rdIdx = r.rdIdx + 7'h01;
				end
			end
			P_IGN: next_sys.ph = P_IGN;
			default: next_sys.ph = P_CMD;
			endcase
		end

		// RULE4 no launch while busy
		if (go && r.st == I_IDLE) begin
			next_sys.ph = P_CMD;
			next_sys.st = I_START;
			next_sys.q = 2'h0;
			next_sys.div = QUARTER_LOAD;
			next_sys.status = ST_BUSY;
			next_sys.intN = 1'b1;
			next_sys.seg = 1'b0;
			next_sys.txIdx = 7'h00;
			next_sys.rxIdx = 7'h00;
			next_sys.toDiv = 7'h00;
			// RULE22 counter load
			next_sys.toCnt = {r.toReg[7:1], TO_ONES};
			// RULE19 buffer replaced
			if (r.cmd == CMD_READ)
				next_sys.rxLen = r.n1;
			else if (r.cmd == CMD_RAW)
				next_sys.rxLen = r.n2;
		end

		if (r.st != I_IDLE) begin
			next_sys.toDiv = r.toDiv + 7'h01;
			if (r.toDiv == TO_DIV_LAST)
				next_sys.toCnt = r.toCnt - 16'h0001;
			// RULE7 quarter-bit timebase
			next_sys.div = tick ? (stretch ? 8'h00 : QUARTER_LOAD)
				: r.div - 8'h01;
		end

		if (adv) begin
			next_sys.q = r.q + 2'h1;
			case (r.st)
			I_START: begin
				case (r.q)
				2'h0: next_sys.sdaOe = 1'b0;
				2'h1: next_sys.sclOe = 1'b0;
				2'h2: begin
					lost = !r.sdaS2;
					next_sys.sdaOe = 1'b1;
				end
				default: begin
					next_sys.sclOe = 1'b1;
					next_sys.st = I_BIT;
					next_sys.bitN = 4'h0;
					next_sys.isAddr = 1'b1;
					next_sys.rdData = 1'b0;
					// RULE13 address bit 0 replaced
					// RULE15 read always reads
					next_sys.ioByte = {segAddr[7:1], segRead};
				end
				endcase
			end
			I_BIT: begin
				case (r.q)
				2'h0: next_sys.sdaOe = !outBit;
				2'h1: next_sys.sclOe = 1'b0;
				2'h2: begin
					if (r.bitN != 4'h8) begin
						lost = !r.rdData && !r.sdaOe && !r.sdaS2;
						next_sys.ioByte = {r.ioByte[6:0], r.sdaS2};
					end else begin
						next_sys.ack = r.sdaS2;
					end
				end
				default: begin
					next_sys.sclOe = 1'b1;
					next_sys.bitN = r.bitN + 4'h1;
					if (r.bitN == 4'h8) begin
						if (!r.rdData && r.ack) begin
							// RULE2 address refused
							// RULE3 data byte refused
							next_sys.pend = r.isAddr ? ST_NAK_ADDR : ST_NAK_DATA;
							next_sys.st = I_STOP;
						end else begin
							// RULE14 received byte stored
							if (r.rdData) begin
								next_sys.rxBuf[r.rxIdx] = r.ioByte;
								next_sys.rxIdx = r.rxIdx + 7'h01;
							end
							nRd = r.isAddr ? segRead : r.rdData;
							left = r.isAddr ? segLen : r.byteLeft;
							if (left == 8'h00) begin
								// RULE17 read follows write
								if (!r.seg && twoSeg) begin
									next_sys.seg = 1'b1;
									next_sys.st = I_START;
								end else begin
									next_sys.pend = ST_OK;
									next_sys.st = I_STOP;
								end
							end else begin
								next_sys.bitN = 4'h0;
								next_sys.isAddr = 1'b0;
								next_sys.rdData = nRd;
								next_sys.byteLeft = left - 8'h01;
								next_sys.ioByte = nRd ? 8'hFF : r.txBuf[r.txIdx];
								if (!nRd)
									next_sys.txIdx = r.txIdx + 7'h01;
							end
						end
					end
				end
				endcase
			end
			I_STOP: begin
				case (r.q)
				2'h0: next_sys.sdaOe = 1'b1;
				2'h1: next_sys.sclOe = 1'b0;
				2'h2: next_sys.sdaOe = 1'b0;
				default: begin
					// RULE1 completion reported
					// RULE12 write completion interrupt
					next_sys.st = I_IDLE;
					next_sys.status = r.pend;
					next_sys.intN = 1'b0;
				end
				endcase
			end
			// RULE23 retry once bus free
			I_WAIT: begin
				next_sys.freeCnt = (r.sclS2 && r.sdaS2) ?
					r.freeCnt + 3'h1 : 3'h0;
				if (r.freeCnt == BUS_FREE_QTR) begin
					next_sys.st = I_START;
					next_sys.q = 2'h0;
					next_sys.seg = 1'b0;
					next_sys.txIdx = 7'h00;
					next_sys.rxIdx = 7'h00;
				end
			end
			default: next_sys.st = I_IDLE;
			endcase
		end

		if (lost) begin
			next_sys.st = I_WAIT;
			next_sys.sclOe = 1'b0;
			next_sys.sdaOe = 1'b0;
			next_sys.freeCnt = 3'h0;
		end

		// RULE5 time-out abort
		if (toHit) begin
			next_sys.st = I_IDLE;
			next_sys.sclOe = 1'b0;
			next_sys.sdaOe = 1'b0;
			next_sys.status = ST_TIMEOUT;
			next_sys.intN = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.csS1 <= 1'b1;
			r.csS2 <= 1'b1;
			r.sclS1 <= 1'b1;
			r.sclS2 <= 1'b1;
			r.sdaS1 <= 1'b1;
			r.sdaS2 <= 1'b1;
			// RULE1 reset status without interrupt
			r.status <= ST_OK;
			r.intN <= 1'b1;
			r.toReg <= TIMEOUT_RST;
		end else begin
			r <= next_sys;
		end
	end

	assign spiMiso = ng.txSh[7];
	assign spiMisoOe = r.misoOe;
	assign sclOut = r.sclOut;
	assign sclOe = r.sclOe;
	assign sdaOut = r.sdaOut;
	assign sdaOe = r.sdaOe;
	assign intN = r.intN;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_done_ok;
		(r.st == I_STOP && adv && r.q == 2'h3 && r.pend == ST_OK && !toHit)
			|=> (r.status == ST_OK && !r.intN);
	endproperty
	a_done_ok: assert property (p_done_ok) else $error("no success status"); // RULE1

	property p_addr_nak;
		(r.st == I_BIT && adv && r.q == 2'h3 && r.bitN == 4'h8 && r.isAddr
			&& r.ack && !toHit) |=> (r.st == I_STOP && r.pend == ST_NAK_ADDR);
	endproperty
	a_addr_nak: assert property (p_addr_nak) else $error("address nak lost"); // RULE2

	property p_data_nak;
		(r.st == I_BIT && adv && r.q == 2'h3 && r.bitN == 4'h8 && !r.isAddr
			&& !r.rdData && r.ack && !toHit) |=> (r.pend == ST_NAK_DATA);
	endproperty
	a_data_nak: assert property (p_data_nak) else $error("data nak lost"); // RULE3

	property p_busy;
		(r.st != I_IDLE) |-> (r.status == ST_BUSY && r.intN);
	endproperty
	a_busy: assert property (p_busy) else $error("busy status wrong"); // RULE4

	property p_timeout;
		toHit |=> (r.st == I_IDLE && r.status == ST_TIMEOUT && !r.intN
			&& !r.sclOe && !r.sdaOe);
	endproperty
	a_timeout: assert property (p_timeout) else $error("time-out missed"); // RULE5

	property p_bad_count;
		(byteEvt && r.ph == P_A1 && badCnt && r.st == I_IDLE)
			|=> (r.status == ST_BAD_COUNT && !r.intN && r.st == I_IDLE);
	endproperty
	a_bad_count: assert property (p_bad_count) else $error("bad count"); // RULE6

	property p_scl_low;
		($rose(r.sclOe) && !toHit) |=> (r.sclOe || r.st == I_IDLE) [*8];
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("scl low too short"); // RULE7

	property p_addr_rw;
		(r.st == I_START && adv && r.q == 2'h3 && !toHit)
			|=> (r.isAddr && r.ioByte[0] == segRead);
	endproperty
	a_addr_rw: assert property (p_addr_rw) else $error("address bit 0"); // RULE13

	property p_rx_store;
		(r.st == I_BIT && adv && r.q == 2'h3 && r.bitN == 4'h8 && r.rdData
			&& !toHit) |=> (r.rxBuf[$past(r.rxIdx)] == $past(r.ioByte));
	endproperty
	a_rx_store: assert property (p_rx_store) else $error("rx not stored"); // RULE14

	property p_cfg;
		(byteEvt && r.ph == P_CFG && rxB == CFG_LSB) |=> r.lsbFirst;
	endproperty
	a_cfg: assert property (p_cfg) else $error("bit order not set"); // RULE21

	property p_to_load;
		($past(r.st) == I_IDLE && r.st == I_START)
			|-> (r.toCnt[8:0] == TO_ONES && r.toCnt[15:9] == r.toReg[7:1]);
	endproperty
	a_to_load: assert property (p_to_load) else $error("time-out load"); // RULE22

endmodule
`default_nettype wire

// file: sib_partners.sv
// Far-side models: a mode 3 SPI host and a byte-level I2C slave.
// Assumes open-drain wires resolved by the bench, pull-ups outside.
`timescale 1ns/1ps
`default_nettype none
module sib_spi_host (
	output var  logic spiClock,
	output var  logic spiSelectN,
	output var  logic spiMosi,
	input  wire logic spiMiso
);
	logic [7:0] txQ[$];
	logic [7:0] rxQ[$];
	logic       lsbFirst;
	initial begin
		spiClock = 1'b1;
		spiSelectN = 1'b1;
		spiMosi = 1'b0;
		lsbFirst = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic frame();
		logic [7:0] b;
		logic [7:0] r;
		rxQ = {};
		r = 8'h00;
		spiSelectN <= 1'b0;
		#103;
		foreach (txQ[k]) begin
			b = txQ[k];
			for (int i = 0; i < 8; i++) begin
				spiClock <= 1'b0;
				spiMosi <= lsbFirst ? b[i] : b[7 - i];
				#170;
				if (lsbFirst)
					r[i] = spiMiso;
				else
					r[7 - i] = spiMiso;
				spiClock <= 1'b1;
				#170;
			end
			rxQ.push_back(r);
			#120;
		end
		spiSelectN <= 1'b1;
		spiMosi <= ~spiMosi;
		#200;
	endtask
endmodule
////////////////////////////////////////////////////////////////////////////
module sib_i2c_slave #(
	parameter logic [6:0] ADDR = 7'h50
) (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       nakData,
	input  wire logic       holdScl,
	input  wire logic [7:0] rdBase,
	output var  logic       sdaLow,
	output var  logic       sclLow
);
	logic [7:0] shiftIn;
	logic [7:0] txByte;
	logic [7:0] addrLog[$];
	logic [7:0] wrLog[$];
	logic       isAddr;
	logic       sel;
	logic       rd;
	int         bitCnt;
	int         nStart;
	initial begin
		{sdaLow, isAddr, sel, rd} = 4'h0;
		{shiftIn, txByte} = 16'h0000;
		bitCnt = 0;
		nStart = 0;
	end
	assign sclLow = holdScl;
	always @(negedge sda) if (scl) begin
		bitCnt = 0;
		isAddr = 1'b1;
		nStart++;
	end
	always @(posedge sda) if (scl) begin
		isAddr = 1'b0;
		sel = 1'b0;
	end
	always @(posedge scl) begin
		shiftIn = {shiftIn[6:0], sda};
		bitCnt++;
	end
	always @(negedge scl) begin
		if (bitCnt == 8) begin
			sdaLow = 1'b0;
			if (isAddr) begin
				addrLog.push_back(shiftIn);
				sel = shiftIn[7:2] == ADDR[6:1];
				rd = shiftIn[0];
				sdaLow = sel;
			end else if (sel && !rd) begin
				wrLog.push_back(shiftIn);
				sdaLow = !nakData;
			end
		end else if (bitCnt == 9) begin
			bitCnt = 0;
			sdaLow = 1'b0;
			if (sel && rd && (isAddr || !shiftIn[0])) begin
				txByte = isAddr ? rdBase : txByte + 8'h01;
				sdaLow = !txByte[7];
			end
			isAddr = 1'b0;
		end else if (sel && rd && !isAddr && bitCnt > 0) begin
			sdaLow = !txByte[7 - bitCnt];
		end
	end
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench of the SPI to I2C command bridge.
// Assumes the partner models and a bridge with two-state idle wires.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sib_pkg::*;
	logic       clock;
	logic       rst_n;
	logic       spiClock;
	logic       spiSelectN;
	logic       spiMosi;
	logic       spiMiso;
	logic       spiMisoOe;
	logic       sclOut;
	logic       sclOe;
	logic       sdaOut;
	logic       sdaOe;
	logic       intN;
	logic       sdaLow;
	logic       sclLow;
	logic       nakData;
	logic       holdScl;
	logic [7:0] rdBase;
	wire        sclW;
	wire        sdaW;
	wire        misoW;
	int         n_errors;
	int         n_compared;
	int         waited;
	assign sclW = !(sclOe && !sclOut) && !sclLow;
	assign sdaW = !(sdaOe && !sdaOut) && !sdaLow;
	// Released MISO shows the inverse, so a late enable is caught
	assign misoW = spiMisoOe ? spiMiso : !spiMiso;
	sib_bridge u_dut (.clock(clock), .rst_n(rst_n), .spiClock(spiClock),
		.spiSelectN(spiSelectN), .spiMosi(spiMosi), .spiMiso(spiMiso),
		.spiMisoOe(spiMisoOe), .sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe),
		.sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe), .intN(intN));
	sib_spi_host u_host (.spiClock(spiClock), .spiSelectN(spiSelectN),
		.spiMosi(spiMosi), .spiMiso(misoW));
	sib_i2c_slave u_slv (.scl(sclW), .sda(sdaW), .nakData(nakData),
		.holdScl(holdScl), .rdBase(rdBase), .sdaLow(sdaLow),
		.sclLow(sclLow));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic send(input logic [7:0] q[$]);
		u_host.txQ = q;
		u_host.frame();
	endtask
	task automatic status(output logic [7:0] s);
		send('{CMD_REG_RD, REG_STATUS, 8'h00});
		s = u_host.rxQ[2];
	endtask
	task automatic close_x(input logic [7:0] exp, input int lim);
		int c;
		logic [7:0] s;
		for (c = 0; c < lim && intN !== 1'b0; c++) @(posedge clock);
		waited = c;
		chk(8'h00, {7'h00, intN});
		status(s);
		chk(exp, s);
		chk(8'h01, {7'h00, intN});
	endtask
	task automatic drive(input logic nk, input logic hs, input logic [7:0] rb);
		@(posedge clock);
		nakData <= nk;
		holdScl <= hs;
		rdBase <= rb;
	endtask
	task automatic give_verdict();
		$display("compared=%0d errors=%0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [7:0] s;
		chk(8'h01, {7'h00, intN});
		chk(8'h00, {5'h00, spiMisoOe, sclOut, sdaOut});
		fork
			status(s);
			begin
				#1005;
				chk(8'h01, {7'h00, spiMisoOe});
			end
		join
		chk(ST_OK, s);
		send('{CMD_REG_RD, 8'h07, 8'h00});
		chk(8'h00, u_host.rxQ[2]);
		$display("test reset done");
	endtask
	task automatic t_write();
		logic [7:0] s;
		send('{CMD_WRITE, 8'h02, 8'hA1, 8'h3C, 8'hC5});
		chk(8'h01, {7'h00, intN});
		status(s);
		chk(ST_BUSY, s);
		close_x(ST_OK, 20000);
		chk(8'hA0, u_slv.addrLog[0]);
		chk(8'h3C, u_slv.wrLog[0]);
		chk(8'hC5, u_slv.wrLog[1]);
		$display("test write done");
	endtask
	task automatic t_nak();
		send('{CMD_WRITE, 8'h01, 8'h30, 8'h11});
		close_x(ST_NAK_ADDR, 20000);
		drive(1'b1, 1'b0, 8'h00);
		send('{CMD_WRITE, 8'h01, 8'hA0, 8'h11});
		close_x(ST_NAK_DATA, 20000);
		drive(1'b0, 1'b0, 8'h00);
		$display("test nak done");
	endtask
	task automatic t_count();
		int n;
		n = u_slv.nStart;
		send('{CMD_WRITE, 8'h00, 8'hA0});
		close_x(ST_BAD_COUNT, 2000);
		send('{CMD_READ, 8'h61, 8'hA0});
		close_x(ST_BAD_COUNT, 2000);
		chk(n[7:0], u_slv.nStart[7:0]);
		$display("test count done");
	endtask
	task automatic t_read();
		drive(1'b0, 1'b0, 8'h10);
		send('{CMD_READ, 8'h03, 8'hA0});
		close_x(ST_OK, 20000);
		chk(8'hA1, u_slv.addrLog[$]);
		drive(1'b0, 1'b0, 8'h70);
		send('{CMD_READ, 8'h02, 8'hA1});
		chk(8'h00, u_host.rxQ[2]);
		close_x(ST_OK, 20000);
		send('{CMD_RBUF, 8'h00, 8'h00});
		chk(8'h70, u_host.rxQ[1]);
		chk(8'h71, u_host.rxQ[2]);
		$display("test read done");
	endtask
	task automatic t_raw();
		u_slv.addrLog = {};
		drive(1'b0, 1'b0, 8'h20);
		send('{CMD_RAW, 8'h01, 8'h02, 8'hA0, 8'h5A});
		close_x(ST_OK, 20000);
		chk(8'h5A, u_slv.wrLog[$]);
		chk(8'hA1, u_slv.addrLog[1]);
		send('{CMD_RBUF, 8'h00, 8'h00});
		chk(8'h20, u_host.rxQ[1]);
		chk(8'h21, u_host.rxQ[2]);
		$display("test read after write done");
	endtask
	task automatic t_waw();
		u_slv.addrLog = {};
		u_slv.wrLog = {};
		send('{CMD_WAW, 8'h01, 8'h01, 8'hA0, 8'h66, 8'hA2, 8'h99});
		close_x(ST_OK, 20000);
		chk(8'hA0, u_slv.addrLog[0]);
		chk(8'hA2, u_slv.addrLog[1]);
		chk(8'h66, u_slv.wrLog[0]);
		chk(8'h99, u_slv.wrLog[1]);
		$display("test write after write done");
	endtask
	task automatic t_config();
		logic [7:0] s;
		send('{CMD_CONFIG, CFG_LSB});
		u_host.lsbFirst = 1'b1;
		status(s);
		chk(ST_OK, s);
		send('{CMD_CONFIG, CFG_MSB});
		u_host.lsbFirst = 1'b0;
		status(s);
		chk(ST_OK, s);
		$display("test config done");
	endtask
	task automatic t_timeout();
		send('{CMD_REG_WR, REG_TIMEOUT, 8'h01});
		send('{CMD_REG_RD, REG_TIMEOUT, 8'h00});
		chk(8'h01, u_host.rxQ[2]);
		drive(1'b0, 1'b1, 8'h00);
		send('{CMD_WRITE, 8'h01, 8'hA0, 8'h11});
		close_x(ST_TIMEOUT, 70000);
		chk(8'h01, {7'h00, waited > 60000});
		drive(1'b0, 1'b0, 8'h00);
		$display("test timeout done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		n_errors = 0;
		n_compared = 0;
		rst_n = 1'b0;
		nakData = 1'b0;
		holdScl = 1'b0;
		rdBase = 8'h00;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		t_reset();
		t_write();
		t_nak();
		t_count();
		t_read();
		t_raw();
		t_waw();
		t_config();
		t_timeout();
		give_verdict();
	end
	initial begin
		#2_600_000;
		n_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
